// ==== logic/eeprom_loader_defines.vh ====
// Constants for the EEPROM configuration autoloader: offsets, fields and timing.
`ifndef EEPROM_LOADER_DEFINES_VH
`define EEPROM_LOADER_DEFINES_VH
`define SIGNATURE_WORD      16'h1516
`define ADDR_SIGNATURE_LO   8'h00
`define ADDR_SIGNATURE_HI   8'h01
`define ADDR_REGION         8'h02
`define ADDR_MISC           8'h03
`define REGION_LSB          1
`define REGION_GROUP1       4'h0
`define REGION_GROUP2       4'h1
`define REGION_GROUP3       4'h3
`define REGION_GROUP4       4'h7
`define STOP_GROUP1         8'h0B
`define STOP_GROUP2         8'h67
`define STOP_GROUP3         8'hAF
`define STOP_GROUP4         8'hD7
`define MISC_ISA_WP_BIT     0
`define CFG_BRIDGE_CTRL     12'h03E
`define ISA_ENABLE_BIT      2
`define EXT_ADDR_FIRST      8'h50
`define EXT_ADDR_LAST       8'h67
`define EXT_PAIR_LEN        8'h06
`define CFG_EXT_ADDR        12'h0E0
`define CFG_EXT_DATA        12'h0E4
`define DEVICE_ADDR         7'h50
`define SCL_FREQ_HZ         100000
`define CLK_FREQ_HZ         40000000
`define SCL_QUARTER_CYCLES  ((`CLK_FREQ_HZ + 4 * `SCL_FREQ_HZ - 1) / (4 * `SCL_FREQ_HZ))
`endif

// ==== logic/byte_fifo.v ====
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset.
  input  wire             clock,
  input  wire             reset_n,
  // Fill side.
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side.
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_r;
  reg [AW-1:0]    rdPtr_r;
  reg [AW:0]      count_r;
  wire            doWrite;
  wire            doRead;

  // Full and empty come from the occupancy count, so they are exact.
  assign inReady  = (count_r != DEPTH[AW:0]);
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_r];
  assign doWrite  = inValid & inReady;
  assign doRead   = outValid & outReady;

  // Storage array has no reset; only pointers and count need a defined start.
  always @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Pointer and count update.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doRead) begin
        rdPtr_r <= rdPtr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doWrite && !doRead) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (doRead && !doWrite) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // byte_fifo

// ==== logic/eeprom_config_autoload.v ====
// EEPROM autoloader that reads a two-wire memory and writes bridge configuration space.
`timescale 1ns/1ps
`include "eeprom_loader_defines.vh"

// Functional notes
// [RULE1] Load continues only when EEPROM word 0 equals the signature value.
// [RULE2] Region-enable byte 02h selects how much configuration is loaded.
// [RULE3] Region code 0000 stops at 0Bh; 0001 stops at 67h.
// [RULE4] Region code 0011 stops at AFh; 0111 stops at D7h.
// [RULE5] EEPROM must use only listed region codes; other bits are reserved.
// [RULE6] Byte 03h bit 0 makes ISA enable bit 2 of 3Eh read-only.
// [RULE7] Miscellaneous controls act only in transparent mode.
// [RULE8] EEPROM byte 09h goes to class code low byte at 09h.
// [RULE9] EEPROM bytes 0A-0Bh go to class code upper bytes 0A-0Bh.
// [RULE10] EEPROM bytes 0D-0Eh go to prefetch control at 40-41h.
// [RULE11] EEPROM bytes 22-25h go to secondary clock control A4-A7h.
// [RULE12] EEPROM 3D-48h go to three PHY tuning words at CC-D7h.
// [RULE13] Four indirect writes: address to E0-E1h, then data to E4-E7h.
// [RULE14] Byte 1Bh goes to 108h; bytes 4E-4Fh go to 109-10Ah.
// [RULE15] Byte 4Dh goes to error reporting capability at 100h.
// [RULE16] Bytes 87-8Ah go to power management control at 94-97h.
// [RULE17] Bytes 79-7Bh go to GPIO data and control at 79-7Bh.
// [RULE18] Bytes B4-B6h go to configuration offsets 0C-0Eh.
// [RULE19] Bytes B8-BBh go to bus numbers at 18-1Bh.
// [RULE20] Bytes BC-BFh go to I/O base, limit, status at 1C-1Fh.
// [RULE21] Bytes C8-CBh go to 28-2Bh; CC-CFh go to 2C-2Fh.
// [RULE22] Bytes D0-D3h go to upper-16 I/O base and limit at 30-33h.
// [RULE23] Loader is active only when both mode straps sample low.
// [RULE24] Device drives the two-wire clock as bus master.
// [RULE25] Data line is driven for address bytes, released for memory data.
// [RULE26] Fetch ascending, skip reserved bytes, hold configuration accesses until done.
// [RULE27] Failed signature or missing acknowledge leaves defaults and ends idle.
// [RULE28] Multi-byte fields land least significant byte first.
module eeprom_config_autoload #(
  parameter QUARTER = `SCL_QUARTER_CYCLES,
  parameter DEPTH   = 16
) (
  // Clock and reset.
  input  wire        clock,
  input  wire        reset_n,
  // Mode straps and bridge mode.
  input  wire        modeStrapHigh,
  input  wire        modeStrapLow,
  input  wire        transparentMode,
  // Two-wire memory pins.
  output wire        eepromSerialClock,
  input  wire        eepromSerialDataLineIn,
  output wire        eepromSerialDataLineOut,
  output wire        eepromSerialDataLineOe,
  // Configuration write port.
  output wire        cfgWrite,
  output wire [11:0] cfgAddr,
  output wire [7:0]  cfgData,
  input  wire        cfgReady,
  // Status.
  output wire        loadBusy,
  output wire        loadDone,
  output wire        loadFailed,
  output wire        isaEnableLocked
);
  localparam S_STRAP = 4'd0, S_START = 4'd1, S_SEND = 4'd2, S_ACK = 4'd3, S_RSTART = 4'd4;
  localparam S_READ = 4'd5, S_MACK = 4'd6, S_STOP = 4'd7, S_DRAIN = 4'd8, S_DONE = 4'd9, S_IDLE = 4'd10;

  reg  [3:0]  state_r;
  reg  [1:0]  phase_r;
  reg  [15:0] tick_r;
  reg  [2:0]  bitCnt_r;
  reg  [7:0]  shift_r;
  reg  [1:0]  sendIdx_r;
  reg  [7:0]  addr_r;
  reg  [7:0]  stopAt_r;
  reg  [15:0] sig_r;
  reg         sclOut_r;
  reg         sdaOe_r;
  reg         failed_r;
  reg         done_r;
  reg         isaLock_r;
  reg         strapTaken_r;
  reg  [2:0]  sdaSync_r;
  reg         sdaIn_r;
  reg  [11:0] cfgOff;
  reg         cfgHit;
  wire        tick;
  wire        fifoInReady;
  wire        fifoOutValid;
  wire [19:0] fifoOut;
  wire        pushByte;
  wire        lastByte;

  // Pin synchroniser: the filtered level changes only when stages two and three agree.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sdaSync_r <= 3'b111;
      sdaIn_r   <= 1'b1;
    end else begin
      sdaSync_r <= {sdaSync_r[1:0], eepromSerialDataLineIn};
      if (sdaSync_r[1] == sdaSync_r[2]) begin
        sdaIn_r <= sdaSync_r[2];
      end
    end
  end

  // Quarter-period timer for the serial clock; stalls while the FIFO is full.
  // QUARTER must be at least 3, or the filtered data line lags the sample point.
  assign tick = (tick_r == 16'h0000) && fifoInReady;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_r <= 16'h0000;
    end else if (tick_r == 16'h0000) begin
      tick_r <= fifoInReady ? QUARTER[15:0] - 16'h0001 : 16'h0000;
    end else begin
      tick_r <= tick_r - 16'h0001;
    end
  end

  // Configuration offset map for each EEPROM byte; reserved bytes are skipped.
  always @* begin
    cfgOff = 12'h000;
    cfgHit = 1'b1;
    if (addr_r == 8'h09 || addr_r == 8'h0A || addr_r == 8'h0B) begin
      cfgOff = {4'h0, addr_r}; // [RULE8] [RULE9]
    end else if (addr_r == 8'h0D || addr_r == 8'h0E) begin
      cfgOff = {4'h0, addr_r} + 12'h033; // [RULE10] [RULE28]
    end else if (addr_r == 8'h1B) begin
      cfgOff = 12'h108; // [RULE14]
    end else if (addr_r >= 8'h22 && addr_r <= 8'h25) begin
      cfgOff = {4'h0, addr_r} + 12'h082; // [RULE11]
    end else if (addr_r >= 8'h3D && addr_r <= 8'h48) begin
      cfgOff = {4'h0, addr_r} + 12'h08F; // [RULE12]
    end else if (addr_r == 8'h4D) begin
      cfgOff = 12'h100; // [RULE15]
    end else if (addr_r == 8'h4E || addr_r == 8'h4F) begin
      cfgOff = {4'h0, addr_r} + 12'h0BB; // [RULE14]
    end else if (addr_r >= `EXT_ADDR_FIRST && addr_r <= `EXT_ADDR_LAST) begin
      if (((addr_r - `EXT_ADDR_FIRST) % `EXT_PAIR_LEN) < 8'h02) begin
        cfgOff = `CFG_EXT_ADDR + {11'h000, (addr_r[0] ^ 1'b0)}; // [RULE13]
      end else begin
        cfgOff = `CFG_EXT_DATA + {4'h0, (((addr_r - `EXT_ADDR_FIRST) % `EXT_PAIR_LEN) - 8'h02)}; // [RULE13]
      end
    end else if (addr_r >= 8'h79 && addr_r <= 8'h7B) begin
      cfgOff = {4'h0, addr_r}; // [RULE17]
    end else if (addr_r >= 8'h87 && addr_r <= 8'h8A) begin
      cfgOff = {4'h0, addr_r} + 12'h00D; // [RULE16]
    end else if (addr_r >= 8'hB4 && addr_r <= 8'hB6) begin
      cfgOff = {4'h0, addr_r} - 12'h0A8; // [RULE18]
    end else if (addr_r >= 8'hB8 && addr_r <= 8'hBF) begin
      cfgOff = {4'h0, addr_r} - 12'h0A0; // [RULE19] [RULE20]
    end else if (addr_r >= 8'hC8 && addr_r <= 8'hD3) begin
      cfgOff = {4'h0, addr_r} - 12'h0A0; // [RULE21] [RULE22]
    end else begin
      cfgHit = 1'b0; // [RULE26]
    end
  end

  // A finished data byte is queued only when it has a mapped destination.
  assign lastByte = (addr_r == stopAt_r);
  assign pushByte = (state_r == S_MACK) && tick && (phase_r == 2'd0) && cfgHit && (addr_r > `ADDR_MISC);

  // Main sequencer: one random read, then sequential reads in ascending order.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_STRAP;
      phase_r <= 2'd0;
      bitCnt_r <= 3'd7;
      shift_r <= 8'h00;
      sendIdx_r <= 2'd0;
      addr_r <= 8'h00;
      stopAt_r <= `STOP_GROUP1;
      sig_r <= 16'h0000;
      sclOut_r <= 1'b1;
      sdaOe_r <= 1'b0;
      failed_r <= 1'b0;
      done_r <= 1'b0;
      isaLock_r <= 1'b0;
      strapTaken_r <= 1'b0;
    end else begin
      case (state_r)
        S_STRAP: begin
          strapTaken_r <= 1'b1;
          if (strapTaken_r) begin
            if (!modeStrapHigh && !modeStrapLow) begin
              state_r <= S_START; // [RULE23]
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_START: if (tick) begin
          sdaOe_r <= 1'b1; // [RULE24]
          phase_r <= phase_r + 2'd1;
          if (phase_r == 2'd1) begin
            sclOut_r <= 1'b0;
            shift_r <= {`DEVICE_ADDR, 1'b0};
            sendIdx_r <= 2'd0;
            bitCnt_r <= 3'd7;
            phase_r <= 2'd0;
            state_r <= S_SEND;
          end
        end
        S_SEND: if (tick) begin
          phase_r <= phase_r + 2'd1;
          if (phase_r == 2'd0) begin
            sdaOe_r <= ~shift_r[7]; // [RULE25]
          end else if (phase_r == 2'd1) begin
            sclOut_r <= 1'b1;
          end else if (phase_r == 2'd3) begin
            sclOut_r <= 1'b0;
            shift_r <= {shift_r[6:0], 1'b0};
            bitCnt_r <= bitCnt_r - 3'd1;
            if (bitCnt_r == 3'd0) begin
              state_r <= S_ACK;
            end
          end
        end
        S_ACK: if (tick) begin
          phase_r <= phase_r + 2'd1;
          if (phase_r == 2'd0) begin
            sdaOe_r <= 1'b0; // [RULE25]
          end else if (phase_r == 2'd1) begin
            sclOut_r <= 1'b1;
          end else if (phase_r == 2'd2 && sdaIn_r) begin
            failed_r <= 1'b1; // [RULE27]
          end else if (phase_r == 2'd3) begin
            sclOut_r <= 1'b0;
            bitCnt_r <= 3'd7;
            sendIdx_r <= sendIdx_r + 2'd1;
            if (failed_r) begin
              state_r <= S_STOP; // A refused address still ends with a stop condition. [RULE27]
            end else if (sendIdx_r == 2'd0) begin
              shift_r <= `ADDR_SIGNATURE_LO;
              state_r <= S_SEND;
            end else if (sendIdx_r == 2'd1) begin
              state_r <= S_RSTART;
            end else begin
              state_r <= S_READ;
            end
          end
        end
        S_RSTART: if (tick) begin
          phase_r <= phase_r + 2'd1;
          if (phase_r == 2'd0) begin
            sdaOe_r <= 1'b0;
          end else if (phase_r == 2'd1) begin
            sclOut_r <= 1'b1;
          end else if (phase_r == 2'd2) begin
            sdaOe_r <= 1'b1;
          end else begin
            sclOut_r <= 1'b0;
            shift_r <= {`DEVICE_ADDR, 1'b1};
            state_r <= S_SEND;
          end
        end
        S_READ: if (tick) begin
          phase_r <= phase_r + 2'd1;
          if (phase_r == 2'd0) begin
            sdaOe_r <= 1'b0; // [RULE25]
          end else if (phase_r == 2'd1) begin
            sclOut_r <= 1'b1;
          end else if (phase_r == 2'd2) begin
            shift_r <= {shift_r[6:0], sdaIn_r};
          end else begin
            sclOut_r <= 1'b0;
            bitCnt_r <= bitCnt_r - 3'd1;
            if (bitCnt_r == 3'd0) begin
              state_r <= S_MACK;
            end
          end
        end
        S_MACK: if (tick) begin
          phase_r <= phase_r + 2'd1;
          if (phase_r == 2'd0) begin
            sdaOe_r <= ~lastByte; // Master acknowledge, or not on the last byte.
            if (addr_r == `ADDR_SIGNATURE_LO) begin
              sig_r[7:0] <= shift_r; // [RULE28]
            end else if (addr_r == `ADDR_SIGNATURE_HI) begin
              sig_r[15:8] <= shift_r;
              if ({shift_r, sig_r[7:0]} != `SIGNATURE_WORD) begin
                failed_r <= 1'b1; // [RULE1] [RULE27]
                stopAt_r <= `ADDR_SIGNATURE_HI;
                sdaOe_r <= 1'b0;
              end else begin
                stopAt_r <= `ADDR_MISC;
              end
            end else if (addr_r == `ADDR_REGION) begin
              // Undefined region codes fall back to the shortest load.
              case (shift_r[`REGION_LSB+3:`REGION_LSB]) // [RULE2] [RULE5]
                `REGION_GROUP2: stopAt_r <= `STOP_GROUP2; // [RULE3]
                `REGION_GROUP3: stopAt_r <= `STOP_GROUP3; // [RULE4]
                `REGION_GROUP4: stopAt_r <= `STOP_GROUP4; // [RULE4]
                default: stopAt_r <= `STOP_GROUP1; // [RULE3]
              endcase
            end else if (addr_r == `ADDR_MISC) begin
              isaLock_r <= shift_r[`MISC_ISA_WP_BIT] & transparentMode; // [RULE6] [RULE7]
            end
          end else if (phase_r == 2'd1) begin
            sclOut_r <= 1'b1;
          end else if (phase_r == 2'd3) begin
            sclOut_r <= 1'b0;
            bitCnt_r <= 3'd7;
            addr_r <= addr_r + 8'h01; // [RULE26]
            state_r <= (lastByte || failed_r) ? S_STOP : S_READ;
          end
        end
        S_STOP: if (tick) begin
          phase_r <= phase_r + 2'd1;
          if (phase_r == 2'd0) begin
            sdaOe_r <= 1'b1;
          end else if (phase_r == 2'd1) begin
            sclOut_r <= 1'b1;
          end else if (phase_r == 2'd2) begin
            sdaOe_r <= 1'b0;
          end else begin
            state_r <= S_DRAIN;
          end
        end
        S_DRAIN: begin
          if (!fifoOutValid) begin
            state_r <= S_DONE;
          end
        end
        S_DONE: begin
          done_r <= 1'b1; // [RULE26]
          state_r <= S_IDLE;
        end
        default: begin
          done_r <= 1'b1;
        end
      endcase
    end
  end

  // Bytes wait here for the configuration port, which may hold them off.
  byte_fifo #(
    .WIDTH (20),
    .DEPTH (DEPTH),
    .AW    (4)
  ) u_fifo (
    .clock    (clock),
    .reset_n  (reset_n),
    .inValid  (pushByte),
    .inReady  (fifoInReady),
    .inData   ({cfgOff, shift_r}),
    .outValid (fifoOutValid),
    .outReady (cfgReady),
    .outData  (fifoOut)
  );

  // Outputs.
  assign eepromSerialClock       = sclOut_r; // [RULE24]
  assign eepromSerialDataLineOut = 1'b0;
  assign eepromSerialDataLineOe  = sdaOe_r;
  assign cfgWrite                = fifoOutValid;
  assign cfgAddr                 = fifoOut[19:8];
  assign cfgData                 = fifoOut[7:0];
  assign loadBusy                = ~done_r; // [RULE26]
  assign loadDone                = done_r;
  assign loadFailed              = failed_r;
  assign isaEnableLocked         = isaLock_r;
endmodule // eeprom_config_autoload

// ==== tb/eeprom_serial_memory.sv ====
// Behavioural two-wire serial memory of 256 bytes behind a pulled-up data line.
`timescale 1ns/1ps
module eeprom_serial_memory #(parameter logic [6:0] DEV = 7'h50) (
  // Two-wire pins.
  input  wire logic scl,
  input  wire logic sda,
  // Refuses every device address byte when high; the word address byte is always acknowledged.
  input  wire logic refuse,
  output logic      pullLow
);
  logic [7:0] mem [256];
  logic [7:0] shiftR;
  logic [7:0] ptr;
  logic       rd = 1'b0;
  logic       active = 1'b0;
  int         cnt = 0;
  int         idx = 0;
  initial pullLow = 1'b0;
  // A falling data line under a high clock opens a transfer; a rising one ends it.
  always @(negedge sda) if (scl === 1'b1) begin
    active = 1'b1;
    rd = 1'b0;
    cnt = -1;
    idx = 0;
  end
  always @(posedge sda) if (scl === 1'b1) active = 1'b0;
  // Bits are taken while the clock is high; a master refusal ends the read.
  always @(posedge scl) if (active) begin
    if (cnt < 8 && !rd) shiftR = {shiftR[6:0], sda};
    if (cnt == 8 && rd && sda) rd = 1'b0;
  end
  // The line only moves after a falling clock, so it never fakes a start or stop.
  always @(negedge scl) if (active) begin
    cnt = (cnt == 8) ? 0 : cnt + 1;
    pullLow = 1'b0;
    if (cnt == 8 && !rd) begin
      if (idx == 0) begin
        pullLow = !refuse && shiftR[7:1] == DEV;
        rd = shiftR[0];
      end else begin
        pullLow = 1'b1;
        ptr = shiftR;
      end
      idx++;
    end else if (cnt == 8) ptr++;
    else if (rd) pullLow = ~mem[ptr][7 - cnt];
  end
endmodule // eeprom_serial_memory

// ==== tb/eeprom_config_autoload_checker.sv ====
// Port-level assertions for the EEPROM configuration autoloader.
`timescale 1ns/1ps
module eeprom_config_autoload_checker #(parameter QUARTER = 2) (
  // Clock, reset and straps.
  input logic        clock, reset_n, modeStrapHigh, modeStrapLow, transparentMode,
  // Two-wire pins.
  input logic        eepromSerialClock, eepromSerialDataLineIn, eepromSerialDataLineOut, eepromSerialDataLineOe,
  // Configuration port and status.
  input logic        cfgWrite, cfgReady, loadBusy, loadDone, loadFailed, isaEnableLocked,
  input logic [11:0] cfgAddr,
  input logic [7:0]  cfgData
);
  int lowCnt;
  // Counts the low cycles of the serial clock; stalls may stretch it, never shorten it.
  always @(posedge clock or negedge reset_n)
    if (!reset_n) lowCnt <= 0;
    else lowCnt <= eepromSerialClock ? 0 : lowCnt + 1;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_write_holds: assert property (cfgWrite && !cfgReady |=> cfgWrite && $stable(cfgAddr) && $stable(cfgData))
    else $error("config write changed while stalled");
  a_fail_quiet: assert property (loadFailed |-> !cfgWrite)
    else $error("config write after failure");
  a_done_stays: assert property (loadDone |=> loadDone && !loadBusy)
    else $error("done dropped or busy still high");
  a_bus_idle_done: assert property (loadDone |-> eepromSerialClock && !eepromSerialDataLineOe)
    else $error("serial bus not idle after load");
  a_sda_drive_low: assert property (eepromSerialDataLineOe |-> !eepromSerialDataLineOut)
    else $error("data line driven high");
  a_strap_quiet: assert property (modeStrapHigh || modeStrapLow |-> eepromSerialClock && !cfgWrite)
    else $error("loader active with other strap setting");
  a_scl_low_phase: assert property ($rose(eepromSerialClock) |-> lowCnt >= QUARTER)
    else $error("serial clock low phase too short");
  a_fail_then_done: assert property ($rose(loadFailed) |-> ##[0:200] loadDone)
    else $error("failure did not end the load");
  a_lock_mode: assert property (isaEnableLocked |-> transparentMode)
    else $error("lock outside transparent mode");
endmodule // eeprom_config_autoload_checker
bind eeprom_config_autoload eeprom_config_autoload_checker #(.QUARTER(QUARTER)) u_checker (
  .clock(clock), .reset_n(reset_n), .modeStrapHigh(modeStrapHigh), .modeStrapLow(modeStrapLow),
  .transparentMode(transparentMode), .eepromSerialClock(eepromSerialClock),
  .eepromSerialDataLineIn(eepromSerialDataLineIn), .eepromSerialDataLineOut(eepromSerialDataLineOut),
  .eepromSerialDataLineOe(eepromSerialDataLineOe), .cfgWrite(cfgWrite), .cfgReady(cfgReady),
  .loadBusy(loadBusy), .loadDone(loadDone), .loadFailed(loadFailed), .isaEnableLocked(isaEnableLocked),
  .cfgAddr(cfgAddr), .cfgData(cfgData));

// ==== tb/eeprom_config_autoload_tb.sv ====
// Self-checking testbench for the EEPROM configuration autoloader.
`timescale 1ns/1ps
module eeprom_config_autoload_tb;
  logic        clock = 0, reset_n = 0, strapHigh = 0, strapLow = 0, transparentMode = 0, cfgReady = 0;
  logic        refuse = 0, memLow, scl, sdaIn, sdaOut, sdaOe;
  logic        cfgWrite, loadBusy, loadDone, loadFailed, isaEnableLocked;
  logic [11:0] cfgAddr;
  logic [7:0]  cfgData;
  logic [19:0] seen [$];
  int          miscompares = 0, samplesChecked = 0, stallCycles = 0, cyc = 0, sclRises = 0;

  always #12.5 clock = ~clock;
  // The data line has a pull-up; either party may pull it low.
  assign sdaIn = (sdaOe ? sdaOut : 1'b1) & ~memLow;

  // Three is the shortest quarter at which the filtered data line settles before it is sampled.
  eeprom_config_autoload #(.QUARTER(3)) u_dut (.clock(clock), .reset_n(reset_n), .modeStrapHigh(strapHigh),
    .modeStrapLow(strapLow), .transparentMode(transparentMode), .eepromSerialClock(scl),
    .eepromSerialDataLineIn(sdaIn), .eepromSerialDataLineOut(sdaOut), .eepromSerialDataLineOe(sdaOe),
    .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgData(cfgData), .cfgReady(cfgReady), .loadBusy(loadBusy),
    .loadDone(loadDone), .loadFailed(loadFailed), .isaEnableLocked(isaEnableLocked));
  eeprom_serial_memory u_mem (.scl(scl), .sda(sdaIn), .refuse(refuse), .pullLow(memLow));

  // The sink records accepted bytes and stalls on request, so the buffer fills up.
  always @(posedge clock) begin
    cyc++;
    if (cfgWrite === 1'b1 && cfgReady === 1'b1) seen.push_back({cfgAddr, cfgData});
    if (stallCycles > 0) stallCycles--;
    cfgReady <= (stallCycles == 0) && (cyc % 3 != 0);
  end
  always @(posedge scl) sclRises++;

  task automatic check(string what, logic [19:0] got, logic [19:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Where each memory byte must land; all ones marks a byte that is read but not written.
  function automatic logic [11:0] mapTo(logic [7:0] a);
    if (a >= 8'h09 && a <= 8'h0B) return {4'h0, a};
    if (a == 8'h0D || a == 8'h0E) return 12'h040 + a - 8'h0D;
    if (a == 8'h1B) return 12'h108;
    if (a >= 8'h22 && a <= 8'h25) return 12'h0A4 + a - 8'h22;
    if (a >= 8'h3D && a <= 8'h48) return 12'h0CC + a - 8'h3D;
    if (a == 8'h4D) return 12'h100;
    if (a == 8'h4E || a == 8'h4F) return 12'h109 + a - 8'h4E;
    if (a >= 8'h50 && a <= 8'h67) return ((a - 8'h50) % 6 < 2) ? 12'h0E0 + (a - 8'h50) % 6 : 12'h0E2 + (a - 8'h50) % 6;
    if (a >= 8'h79 && a <= 8'h7B) return {4'h0, a};
    if (a >= 8'h87 && a <= 8'h8A) return 12'h094 + a - 8'h87;
    if (a >= 8'hB4 && a <= 8'hB6) return 12'h00C + a - 8'hB4;
    if (a >= 8'hB8 && a <= 8'hBF) return 12'h018 + a - 8'hB8;
    if (a >= 8'hC8 && a <= 8'hD3) return 12'h028 + a - 8'hC8;
    return 12'hFFF;
  endfunction

  // Loads the memory, resets the block with the given straps and waits for the load to end.
  task automatic startRun(logic sh, logic sl, logic tm, logic [7:0] region, logic [7:0] misc, logic [15:0] sig);
    @(posedge clock);
    reset_n <= 1'b0;
    strapHigh <= sh;
    strapLow <= sl;
    transparentMode <= tm;
    for (int i = 4; i < 256; i++) u_mem.mem[i] = i[7:0] ^ 8'hA5;
    u_mem.mem[0] = sig[7:0];
    u_mem.mem[1] = sig[15:8];
    u_mem.mem[2] = region;
    u_mem.mem[3] = misc;
    repeat (8) @(posedge clock);
    seen.delete();
    sclRises = 0;
    reset_n <= 1'b1;
    for (int n = 0; n < 40000 && (loadDone !== 1'b1 || cfgWrite !== 1'b0); n++) @(posedge clock);
    @(posedge clock);
  endtask

  // A full load for one region code; every mapped byte must arrive in ascending order.
  task automatic groupRun(logic [3:0] code, logic [7:0] stop, logic tm, logic [7:0] misc, int stall);
    int k;
    stallCycles = stall;
    startRun(1'b0, 1'b0, tm, {3'b000, code, 1'b0}, misc, 16'h1516);
    k = 0;
    for (int i = 0; i <= stop; i++) begin
      if (mapTo(i[7:0]) != 12'hFFF) begin
        check("cfg write", (k < seen.size()) ? seen[k] : 20'h0, {mapTo(i[7:0]), i[7:0] ^ 8'hA5});
        k++;
      end
    end
    check("write count", 20'(seen.size()), 20'(k));
    check("isa lock", {19'h0, isaEnableLocked}, {19'h0, misc[0] & tm});
    check("failed", {19'h0, loadFailed}, 20'h0);
    check("busy", {19'h0, loadBusy}, 20'h0);
  endtask

  // A bad signature or a refused address byte must leave every register untouched.
  task automatic failRun(logic [15:0] sig, logic nack);
    refuse = nack;
    startRun(1'b0, 1'b0, 1'b1, 8'h0E, 8'h01, sig);
    refuse = 1'b0;
    check("fail flag", {19'h0, loadFailed}, 20'h1);
    check("fail writes", 20'(seen.size()), 20'h0);
    check("fail lock", {19'h0, isaEnableLocked}, 20'h0);
  endtask

  // Any other strap setting keeps the serial clock still and writes nothing.
  task automatic strapRun(logic sh, logic sl);
    startRun(sh, sl, 1'b1, 8'h0E, 8'h01, 16'h1516);
    check("strap writes", 20'(seen.size()), 20'h0);
    check("strap clock", 20'(sclRises), 20'h0);
    check("strap done", {19'h0, loadDone}, 20'h1);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // The watchdog allows roughly one and a half times the expected run length.
  initial begin
    repeat (90000) @(posedge clock);
    miscompares++;
    results();
  end

  initial begin
    groupRun(4'h0, 8'h0B, 1'b1, 8'h01, 0);
    groupRun(4'h1, 8'h67, 1'b1, 8'h00, 0);
    groupRun(4'h3, 8'hAF, 1'b0, 8'h01, 0);
    groupRun(4'h7, 8'hD7, 1'b1, 8'h01, 12000);
    failRun(16'h1615, 1'b0);
    failRun(16'h1517, 1'b0);
    failRun(16'h1516, 1'b1);
    strapRun(1'b0, 1'b1);
    strapRun(1'b1, 1'b0);
    strapRun(1'b1, 1'b1);
    results();
  end
endmodule // eeprom_config_autoload_tb
